// ---- gpf_ports.sv ----
// Behaviour
// - eight port-0 interrupt flags, set by pin event, cleared by writing 1, reset 0.
// - bits 6-4 pick port-0 upper nibble debounce: 0 none, 1-7 256..16384 cycles.
// - bits 2-0 pick port-0 lower nibble debounce, same mapping, reset none.
// - port-1 bits 6-4 pick upper nibble debounce, same mapping, reset none.
// - 2-bit key reset: fires when pins 1-0, 2-0 or 3-0 all low; 0 off.
// - per-pin port-0 input enable, reset all enabled.
// - port-1 level register read-only, bit 1 reads 0.
// - port-1 drive level register, 8-bit read/write, reset zero.
// - per-pin port-1 driver enable, reset all off.
// - per-pin port-1 pull-up enable, reset all on.
// - per-pin port-0 edge select: 1 falling, 0 rising, reset rising.
// - per-pin port-0 interrupt enable lets a set flag request interrupt, reset off.
// - port-1 bits 2-0 pick lower nibble debounce, same mapping, reset none.
`timescale 1ns/10ps
module gpf_ports
  import gpf_pkg::*;
#(
  parameter int P_DBNC_BASE = GPF_DBNC_BASE_CYC
)
(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  // apb slave
  input  wire gpf_pkg::gpf_apb_req_s i_apb,
  output logic                       o_pready,
  output logic [31:0]                o_prdata,
  output logic                       o_pslverr,
  // port 0 pins
  input  wire logic [7:0]            i_p0_pin,
  // port 1 pins
  input  wire logic [7:0]            i_p1_pin,
  output logic [7:0]                 o_port1_drive_levels,
  output logic [7:0]                 o_p1_oe,
  output logic [7:0]                 o_p1_pullup,
  // events
  output logic                       o_p0_irq,
  output logic                       o_key_reset
);
  import gpf_pkg::*;

  // register file
  logic [7:0] irq_en_reg;
  logic [7:0] edge_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] p0_dbnc_reg;
  logic [7:0] krst_reg;
  logic [7:0] gate_reg;
  logic [7:0] drive_reg;
  logic [7:0] drv_en_reg;
  logic [7:0] pullup_reg;
  logic [7:0] p1_dbnc_reg;
  logic       pready_reg;
  logic       pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic       irq_reg;
  logic       krst_out_reg;
  logic [7:0] p0_prev_reg;

  // apb decode
  wire [15:0] idx       = i_apb.paddr[17:2];
  wire        aligned   = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr[31:18] == 14'h0);
  wire        access    = i_apb.psel && i_apb.penable && !pready_reg;
  wire        done      = i_apb.psel && i_apb.penable && pready_reg;
  wire        wr_done   = done && i_apb.pwrite;
  wire [7:0]  wdata     = i_apb.pwdata[7:0];
  wire        hit_lvl0  = aligned && (idx == GPF_IDX_P0_LEVELS);
  wire        hit_ien   = aligned && (idx == GPF_IDX_P0_IRQ_EN);
  wire        hit_edge  = aligned && (idx == GPF_IDX_P0_EDGE);
  wire        hit_flag  = aligned && (idx == GPF_IDX_P0_FLAGS);
  wire        hit_dbn0  = aligned && (idx == GPF_IDX_P0_DBNC);
  wire        hit_krst  = aligned && (idx == GPF_IDX_PORT0_KEY_RESET_CFG);
  wire        hit_gate  = aligned && (idx == GPF_IDX_P0_GATE);
  wire        hit_lvl1  = aligned && (idx == GPF_IDX_P1_LEVELS);
  wire        hit_drv   = aligned && (idx == GPF_IDX_P1_DRIVE);
  wire        hit_oe    = aligned && (idx == GPF_IDX_P1_DRV_EN);
  wire        hit_pu    = aligned && (idx == GPF_IDX_P1_PULLUP);
  wire        hit_dbn1  = aligned && (idx == GPF_IDX_P1_DBNC);
  wire        hit_any   = hit_lvl0 | hit_ien | hit_edge | hit_flag | hit_dbn0 | hit_krst
                        | hit_gate | hit_lvl1 | hit_drv | hit_oe | hit_pu | hit_dbn1;
  // writes to read-only levels are refused
  wire        bad_acc   = !hit_any || (i_apb.pwrite && (hit_lvl0 || hit_lvl1));

  // debounce: four nibble groups, p0 lo, p0 hi, p1 lo, p1 hi
  wire [3:0] nib_raw [4];
  wire [2:0] nib_code [4];
  logic [3:0] nib_filt [4];
  logic [GPF_DBNC_CNT_W-1:0] nib_cnt [4];
  logic [GPF_DBNC_CNT_W-1:0] nib_thr [4];

  wire [7:0] p0_gated = i_p0_pin & gate_reg;
  assign nib_raw[0]  = p0_gated[3:0];
  assign nib_raw[1]  = p0_gated[7:4];
  assign nib_raw[2]  = i_p1_pin[3:0];
  assign nib_raw[3]  = i_p1_pin[7:4];
  assign nib_code[0] = p0_dbnc_reg[GPF_DBNC_LO_LSB +: GPF_DBNC_W];
  assign nib_code[1] = p0_dbnc_reg[GPF_DBNC_HI_LSB +: GPF_DBNC_W];
  assign nib_code[2] = p1_dbnc_reg[GPF_DBNC_LO_LSB +: GPF_DBNC_W];
  assign nib_code[3] = p1_dbnc_reg[GPF_DBNC_HI_LSB +: GPF_DBNC_W];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_nib
      logic [3:0] samp_reg;
      // window is base shifted by code-1 cycles
      assign nib_thr[g] = (nib_code[g] == 3'h0) ? '0 :
        GPF_DBNC_CNT_W'(P_DBNC_BASE) << (nib_code[g] - 3'h1);
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_b)
        begin
          samp_reg     <= 4'h0;
          nib_filt[g]  <= 4'h0;
          nib_cnt[g]   <= '0;
        end
        else if (nib_code[g] == 3'h0)
        begin
          samp_reg     <= nib_raw[g];
          nib_filt[g]  <= nib_raw[g];
          nib_cnt[g]   <= '0;
        end
        else if (nib_raw[g] != samp_reg)
        begin
          samp_reg     <= nib_raw[g];
          nib_cnt[g]   <= '0;
        end
        else if (samp_reg != nib_filt[g])
        begin
          // level held for the whole window
          if (nib_cnt[g] >= nib_thr[g] - GPF_DBNC_CNT_W'(1))
          begin
            nib_filt[g] <= samp_reg;
            nib_cnt[g]  <= '0;
          end
          else
            nib_cnt[g]  <= nib_cnt[g] + GPF_DBNC_CNT_W'(1);
        end
      end
    end
  endgenerate

  wire [7:0] p0_filt = {nib_filt[1], nib_filt[0]};
  wire [7:0] p1_filt = {nib_filt[3], nib_filt[2]};

  // edge detection on filtered level
  wire [7:0] p0_rise  = p0_filt & ~p0_prev_reg;
  wire [7:0] p0_fall  = ~p0_filt & p0_prev_reg;
  wire [7:0] p0_event = (p0_rise & ~edge_reg) | (p0_fall & edge_reg);
  wire [7:0] flag_clr = (wr_done && hit_flag) ? wdata : 8'h00;

  // set wins over clear
  assign flags_next = (flags_reg & ~flag_clr) | p0_event;

  // key-entry reset on filtered low pins
  wire [1:0] krst_code  = krst_reg[GPF_KRST_W-1:0];
  wire       krst_match = (krst_code == GPF_KRST_PIN1 && p0_filt[1:0] == 2'h0)
                       || (krst_code == GPF_KRST_PIN2 && p0_filt[2:0] == 3'h0)
                       || (krst_code == GPF_KRST_PIN3 && p0_filt[3:0] == 4'h0);

  // read mux
  always_comb
  begin
    prdata_next = 32'h0;
    case (1'b1)
      hit_lvl0: prdata_next[7:0] = p0_filt;
      hit_ien:  prdata_next[7:0] = irq_en_reg;
      hit_edge: prdata_next[7:0] = edge_reg;
      hit_flag: prdata_next[7:0] = flags_reg;
      hit_dbn0: prdata_next[7:0] = p0_dbnc_reg;
      hit_krst: prdata_next[7:0] = krst_reg;
      hit_gate: prdata_next[7:0] = gate_reg;
      hit_lvl1: prdata_next[7:0] = p1_filt & GPF_P1_LVL_MASK;
      hit_drv:  prdata_next[7:0] = drive_reg;
      hit_oe:   prdata_next[7:0] = drv_en_reg;
      hit_pu:   prdata_next[7:0] = pullup_reg;
      hit_dbn1: prdata_next[7:0] = p1_dbnc_reg;
      default:  prdata_next = 32'h0;
    endcase
  end

  // bus handshake: one wait state
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end
    else
    begin
      pready_reg  <= access;
      pslverr_reg <= access && bad_acc;
      prdata_reg  <= (access && !i_apb.pwrite) ? prdata_next : 32'h0;
    end
  end

  // register writes
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      irq_en_reg  <= GPF_RST_ZERO;
      edge_reg    <= GPF_RST_ZERO;
      p0_dbnc_reg <= GPF_RST_ZERO;
      krst_reg    <= GPF_RST_ZERO;
      gate_reg    <= GPF_RST_GATE;
      drive_reg   <= GPF_RST_ZERO;
      drv_en_reg  <= GPF_RST_ZERO;
      pullup_reg  <= GPF_RST_PULLUP;
      p1_dbnc_reg <= GPF_RST_ZERO;
    end
    else if (wr_done)
    begin
      if (hit_ien)
        irq_en_reg  <= wdata;
      if (hit_edge)
        edge_reg    <= wdata;
      if (hit_dbn0)
        p0_dbnc_reg <= wdata & GPF_DBNC_MASK;
      if (hit_krst)
        krst_reg    <= wdata & GPF_KRST_MASK;
      if (hit_gate)
        gate_reg    <= wdata;
      if (hit_drv)
        drive_reg   <= wdata;
      if (hit_oe)
        drv_en_reg  <= wdata;
      if (hit_pu)
        pullup_reg  <= wdata;
      if (hit_dbn1)
        p1_dbnc_reg <= wdata & GPF_DBNC_MASK;
    end
  end

  // flags, edge history and event outputs
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      flags_reg    <= GPF_RST_ZERO;
      p0_prev_reg  <= 8'h00;
      irq_reg      <= 1'b0;
      krst_out_reg <= 1'b0;
    end
    else
    begin
      flags_reg    <= flags_next;
      p0_prev_reg  <= p0_filt;
      irq_reg      <= |(flags_reg & irq_en_reg);
      krst_out_reg <= krst_match;
    end
  end

  assign o_pready    = pready_reg;
  assign o_pslverr   = pslverr_reg;
  assign o_prdata    = prdata_reg;
  assign o_port1_drive_levels    = drive_reg;
  assign o_p1_oe     = drv_en_reg;
  assign o_p1_pullup = pullup_reg;
  assign o_p0_irq    = irq_reg;
  assign o_key_reset = krst_out_reg;

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_flag_sets_event: assert property (
    p0_event != 8'h00 |=> (flags_reg & $past(p0_event)) == $past(p0_event))
    else $error("flag not set by pin event");

  a_flag_w1c_clear: assert property (
    wr_done && hit_flag && p0_event == 8'h00 |=>
      (flags_reg == ($past(flags_reg) & ~$past(wdata))))
    else $error("flag write-one-clear wrong");

  a_dbnc_upper_wait: assert property (
    nib_code[1] != 3'h0 && nib_filt[1] != $past(nib_filt[1]) && $past(nib_code[1]) == nib_code[1]
      |-> $past(nib_cnt[1]) >= $past(nib_thr[1]) - GPF_DBNC_CNT_W'(1))
    else $error("p0 upper nibble passed early");

  a_dbnc_lower_wait: assert property (
    nib_code[0] != 3'h0 && nib_filt[0] != $past(nib_filt[0]) && $past(nib_code[0]) == nib_code[0]
      |-> $past(nib_cnt[0]) >= $past(nib_thr[0]) - GPF_DBNC_CNT_W'(1))
    else $error("p0 lower nibble passed early");

  a_dbnc_p1_wait: assert property (
    nib_code[3] != 3'h0 && nib_filt[3] != $past(nib_filt[3]) && $past(nib_code[3]) == nib_code[3]
      |-> $past(nib_cnt[3]) >= $past(nib_thr[3]) - GPF_DBNC_CNT_W'(1))
    else $error("p1 upper nibble passed early");

  a_key_reset_low: assert property (
    krst_code == GPF_KRST_PIN2 && p0_filt[2:0] == 3'h0 |=> o_key_reset)
    else $error("key reset missed");

  a_key_reset_off: assert property (
    krst_code == GPF_KRST_OFF |=> !o_key_reset)
    else $error("key reset while disabled");

  a_gate_blocks_pin: assert property (
    nib_code[0] == 3'h0 && nib_code[1] == 3'h0 |=> (p0_filt & ~$past(gate_reg)) == 8'h00)
    else $error("gated pin leaks");

  a_p1_bit1_zero: assert property (
    access && !i_apb.pwrite && hit_lvl1 |=> o_pready && o_prdata[1] == 1'b0)
    else $error("p1 reserved bit reads 1");

  a_p1_drive_write: assert property (
    wr_done && hit_drv |=> o_port1_drive_levels == $past(wdata))
    else $error("drive level not written");

  a_irq_follows_flag: assert property (
    (flags_reg & irq_en_reg) != 8'h00 |=> o_p0_irq)
    else $error("irq not raised");

  a_oe_write: assert property (
    wr_done && hit_oe |=> o_p1_oe == $past(wdata))
    else $error("driver enable not written");

  a_pullup_write: assert property (
    wr_done && hit_pu |=> o_p1_pullup == $past(wdata))
    else $error("pull-up enable not written");

  // a newly set flag must match the selected edge of its filtered pin
  a_edge_polarity: assert property (
    ##1 (flags_reg & ~$past(flags_reg))
      == ((($past(p0_filt) & ~$past(p0_prev_reg) & ~$past(edge_reg))
      | (~$past(p0_filt) & $past(p0_prev_reg) & $past(edge_reg))) & ~$past(flags_reg)))
    else $error("flag set by wrong edge");

  c_rise_event: cover property (p0_rise != 8'h00 && edge_reg == 8'h00);
  c_fall_event: cover property (p0_fall != 8'h00 && edge_reg != 8'h00);
  c_key_reset:  cover property ($rose(o_key_reset));
  c_flag_clear: cover property (wr_done && hit_flag && flags_reg != 8'h00);

endmodule

// ---- gpf_pkg.sv ----
package gpf_pkg;

  // apb request bundle from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } gpf_apb_req_s;

  // register indices; byte address is four times the index
  localparam logic [15:0] GPF_IDX_P0_LEVELS   = 16'h5200;
  localparam logic [15:0] GPF_IDX_P0_IRQ_EN   = 16'h5205;
  localparam logic [15:0] GPF_IDX_P0_EDGE     = 16'h5206;
  localparam logic [15:0] GPF_IDX_P0_FLAGS    = 16'h5207;
  localparam logic [15:0] GPF_IDX_P0_DBNC     = 16'h5208;
  localparam logic [15:0] GPF_IDX_PORT0_KEY_RESET_CFG     = 16'h5209;
  localparam logic [15:0] GPF_IDX_P0_GATE     = 16'h520a;
  localparam logic [15:0] GPF_IDX_P1_LEVELS   = 16'h5210;
  localparam logic [15:0] GPF_IDX_P1_DRIVE    = 16'h5211;
  localparam logic [15:0] GPF_IDX_P1_DRV_EN   = 16'h5212;
  localparam logic [15:0] GPF_IDX_P1_PULLUP   = 16'h5213;
  localparam logic [15:0] GPF_IDX_P1_DBNC     = 16'h5218;

  // field positions
  localparam int GPF_DBNC_HI_LSB = 4;
  localparam int GPF_DBNC_LO_LSB = 0;
  localparam int GPF_DBNC_W      = 3;
  localparam int GPF_KRST_W      = 2;

  // writable masks and port-1 level read mask (reserved bits stay 0)
  localparam logic [7:0] GPF_DBNC_MASK   = 8'h77;
  localparam logic [7:0] GPF_KRST_MASK   = 8'h03;
  localparam logic [7:0] GPF_P1_LVL_MASK = 8'hfd;

  // reset values
  localparam logic [7:0] GPF_RST_ZERO   = 8'h00;
  localparam logic [7:0] GPF_RST_GATE   = 8'hff;
  localparam logic [7:0] GPF_RST_PULLUP = 8'hff;

  // key-entry reset codes
  localparam logic [1:0] GPF_KRST_OFF  = 2'h0;
  localparam logic [1:0] GPF_KRST_PIN1 = 2'h1;
  localparam logic [1:0] GPF_KRST_PIN2 = 2'h2;
  localparam logic [1:0] GPF_KRST_PIN3 = 2'h3;

  // shortest debounce window, in peripheral clock cycles
  localparam int GPF_DBNC_BASE_CYC = 256;
  localparam int GPF_DBNC_CNT_W    = 15;

endpackage

// ---- gpf_pin_model.sv ----
`timescale 1ns/10ps
module gpf_pin_model
(
  // clock
  input  wire logic       i_clk,
  // block side of port 1
  input  wire logic [7:0] i_port1_drive_levels,
  input  wire logic [7:0] i_p1_oe,
  input  wire logic [7:0] i_p1_pullup,
  // external driver on port 1
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_en,
  // resolved pin levels
  output logic [7:0]      o_p1_pin
);
  logic [7:0] noise_reg = 8'h5a;

  // floating pins change every cycle so no stale level is seen
  always @(posedge i_clk)
  begin
    noise_reg <= ~noise_reg;
  end

  // block driver wins, then outside driver, then pull-up, else floating
  assign o_p1_pin = (i_p1_oe & i_port1_drive_levels) | (~i_p1_oe & i_ext_en & i_ext_val)
                  | (~i_p1_oe & ~i_ext_en & i_p1_pullup)
                  | (~i_p1_oe & ~i_ext_en & ~i_p1_pullup & noise_reg);
endmodule

// ---- gpio_ports_filter_keyreset_tb_top.sv ----
`timescale 1ns/10ps
module gpio_ports_filter_keyreset_tb_top;
  import gpf_pkg::*;
  localparam int BASE = 4;
  localparam logic [15:0] RST_IDX [10] = '{GPF_IDX_P0_IRQ_EN, GPF_IDX_P0_EDGE, GPF_IDX_P0_FLAGS,
    GPF_IDX_P0_DBNC, GPF_IDX_P0_GATE, GPF_IDX_P1_DRIVE, GPF_IDX_P1_DRV_EN, GPF_IDX_P1_PULLUP,
    GPF_IDX_P1_DBNC, GPF_IDX_PORT0_KEY_RESET_CFG};
  localparam logic [7:0] RST_VAL [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
    8'hff, 8'h00, 8'h00};
  logic         i_clk;
  logic         i_rst_b;
  gpf_apb_req_s apb;
  logic         o_pready;
  logic [31:0]  o_prdata;
  logic         o_pslverr;
  logic [7:0]   p0_pin;
  logic [7:0]   p1_pin;
  logic [7:0]   port1_drive_levels;
  logic [7:0]   p1_oe;
  logic [7:0]   p1_pullup;
  logic [7:0]   ext_val;
  logic [7:0]   ext_en;
  logic         o_p0_irq;
  logic         o_key_reset;
  int           err_total;
  int           checked;

  gpf_ports #(.P_DBNC_BASE(BASE)) u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_apb(apb),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_p0_pin(p0_pin),
    .i_p1_pin(p1_pin), .o_port1_drive_levels(port1_drive_levels), .o_p1_oe(p1_oe), .o_p1_pullup(p1_pullup),
    .o_p0_irq(o_p0_irq), .o_key_reset(o_key_reset));
  gpf_pin_model u_pins (.i_clk(i_clk), .i_port1_drive_levels(port1_drive_levels), .i_p1_oe(p1_oe),
    .i_p1_pullup(p1_pullup), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_p1_pin(p1_pin));

  initial i_clk = 1'b0;
  always #25 i_clk = ~i_clk;

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge i_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {14'h0, idx, 2'b00}, pwdata: wd};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    apb <= '0;
    chk(32'(n), 32'h2);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, idx, {24'hffffff, d}, rd, err);
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    logic        err;
    xfer(1'b0, idx, 32'h0, rd, err);
    chk(rd, {24'h0, exp});
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic refused(input logic w, input logic [15:0] idx);
    logic [31:0] rd;
    logic        err;
    xfer(w, idx, 32'hff, rd, err);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic t_reset();
    chk({8'h0, p1_pullup, p1_oe, port1_drive_levels}, 32'hff0000);
    chk({30'h0, o_p0_irq, o_key_reset}, 32'h0);
    for (int i = 0; i < 5; i++)
      rdc(RST_IDX[i], RST_VAL[i]);
    for (int i = 5; i < 10; i++)
      rdc(RST_IDX[i], RST_VAL[i]);
  endtask

  task automatic t_mask();
    wr(GPF_IDX_P0_DBNC, 8'hff);
    rdc(GPF_IDX_P0_DBNC, 8'h77);
    wr(GPF_IDX_P0_DBNC, 8'h00);
    wr(GPF_IDX_PORT0_KEY_RESET_CFG, 8'hff);
    rdc(GPF_IDX_PORT0_KEY_RESET_CFG, 8'h03);
    wr(GPF_IDX_PORT0_KEY_RESET_CFG, 8'h00);
    wr(GPF_IDX_P1_DBNC, 8'hff);
    rdc(GPF_IDX_P1_DBNC, 8'h77);
    wr(GPF_IDX_P1_DBNC, 8'h00);
    refused(1'b1, GPF_IDX_P1_LEVELS);
    refused(1'b0, 16'h5204);
  endtask

  task automatic t_p1();
    wr(GPF_IDX_P1_DRIVE, 8'ha7);
    wr(GPF_IDX_P1_DRV_EN, 8'h0f);
    cyc(1);
    chk({24'h0, port1_drive_levels}, 32'ha7);
    chk({24'h0, p1_oe}, 32'h0f);
    rdc(GPF_IDX_P1_DRIVE, 8'ha7);
    rdc(GPF_IDX_P1_LEVELS, 8'hf5);
    wr(GPF_IDX_P1_PULLUP, 8'h00);
    ext_en <= 8'hf0;
    ext_val <= 8'h32;
    cyc(2);
    chk({24'h0, p1_pullup}, 32'h0);
    rdc(GPF_IDX_P1_LEVELS, 8'h35);
  endtask

  task automatic t_irq();
    wr(GPF_IDX_P0_IRQ_EN, 8'h03);
    wr(GPF_IDX_P0_EDGE, 8'h02);
    p0_pin <= 8'h03;
    cyc(4);
    rdc(GPF_IDX_P0_FLAGS, 8'h01);
    chk({31'h0, o_p0_irq}, 32'h1);
    wr(GPF_IDX_P0_FLAGS, 8'h00);
    rdc(GPF_IDX_P0_FLAGS, 8'h01);
    p0_pin <= 8'h00;
    cyc(4);
    rdc(GPF_IDX_P0_FLAGS, 8'h03);
    wr(GPF_IDX_P0_FLAGS, 8'h01);
    rdc(GPF_IDX_P0_FLAGS, 8'h02);
    wr(GPF_IDX_P0_FLAGS, 8'h02);
    cyc(2);
    chk({31'h0, o_p0_irq}, 32'h0);
    wr(GPF_IDX_P0_IRQ_EN, 8'h00);
    p0_pin <= 8'h01;
    cyc(4);
    rdc(GPF_IDX_P0_FLAGS, 8'h01);
    chk({31'h0, o_p0_irq}, 32'h0);
    wr(GPF_IDX_P0_FLAGS, 8'hff);
  endtask

  task automatic t_krst();
    logic [7:0] m;
    for (int c = 1; c < 4; c++)
    begin
      m = (8'h1 << (c + 1)) - 8'h1;
      wr(GPF_IDX_PORT0_KEY_RESET_CFG, 8'(c));
      p0_pin <= ~m | (8'h1 << c);
      cyc(4);
      chk({31'h0, o_key_reset}, 32'h0);
      p0_pin <= ~m;
      cyc(4);
      chk({31'h0, o_key_reset}, 32'h1);
    end
    wr(GPF_IDX_PORT0_KEY_RESET_CFG, 8'h00);
    cyc(3);
    chk({31'h0, o_key_reset}, 32'h0);
    p0_pin <= 8'hff;
    wr(GPF_IDX_P0_GATE, 8'hf0);
    cyc(2);
    rdc(GPF_IDX_P0_LEVELS, 8'hf0);
    wr(GPF_IDX_PORT0_KEY_RESET_CFG, 8'h01);
    cyc(3);
    chk({31'h0, o_key_reset}, 32'h1);
    wr(GPF_IDX_PORT0_KEY_RESET_CFG, 8'h00);
    wr(GPF_IDX_P0_GATE, 8'hff);
    p0_pin <= 8'h00;
    cyc(4);
  endtask

  // a pulse shorter than the window is dropped, a held level passes
  task automatic dbnc_one(input int sh, input int c);
    int         w;
    logic [7:0] b;
    w = BASE << (c - 1);
    b = 8'h1 << sh;
    wr(GPF_IDX_P0_DBNC, 8'(c) << sh);
    p0_pin <= b;
    cyc(w - 1);
    p0_pin <= 8'h00;
    cyc(w + 4);
    rdc(GPF_IDX_P0_LEVELS, 8'h00);
    p0_pin <= b;
    cyc(w + 4);
    rdc(GPF_IDX_P0_LEVELS, b);
    p0_pin <= 8'h00;
    cyc(w + 4);
  endtask

  task automatic t_dbnc();
    for (int c = 1; c < 8; c++)
    begin
      dbnc_one(0, c);
      dbnc_one(4, c);
    end
    wr(GPF_IDX_P0_DBNC, 8'h00);
    wr(GPF_IDX_P1_DRV_EN, 8'h00);
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    wr(GPF_IDX_P1_DBNC, 8'h31);
    cyc(40);
    ext_val <= 8'h11;
    cyc(8);
    rdc(GPF_IDX_P1_LEVELS, 8'h01);
    cyc(20);
    rdc(GPF_IDX_P1_LEVELS, 8'h11);
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    err_total = 0;
    checked = 0;
    i_rst_b = 1'b0;
    apb = '0;
    p0_pin = 8'h00;
    ext_val = 8'h00;
    ext_en = 8'h00;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_mask();
    t_p1();
    t_irq();
    t_krst();
    t_dbnc();
    report_and_stop();
  end
endmodule
